// [rtl/cpbs_pkg.sv]
package cpbs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  // Refill window that closes a change of flow
  localparam int unsigned COF_IDLE_NS   = 200;
  localparam int unsigned COF_IDLE_CYC  = (COF_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [2:0]  PIPE_MIN_WORDS = 3'h2;
  localparam logic [2:0]  PIPE_MAX_WORDS = 3'h3;
  localparam int unsigned PIPE_STAGES    = 3;
  localparam int unsigned STG_BUF        = 0;
  localparam int unsigned STG_DEC        = 1;
  localparam int unsigned STG_EXE        = 2;

  localparam int unsigned WORD_W   = 16;
  localparam int unsigned LONG_W   = 32;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned WORD_HI  = 31;
  localparam int unsigned WORD_LO  = 16;

  localparam logic [15:0] COF_MASK_DEF  = 16'hf000;
  localparam logic [15:0] COF_MATCH_DEF = 16'h6000;
  localparam logic [1:0]  IDLE_CNT_RST  = 2'h0;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } cpbs_size_type;

  typedef enum logic [1:0] {
    PF_IDLE  = 2'h0,
    PF_FILL  = 2'h1,
    PF_EXTRA = 2'h2,
    PF_RUN   = 2'h3
  } cpbs_pf_type;

  typedef enum logic [1:0] {
    BC_IDLE  = 2'h0,
    BC_FETCH = 2'h1,
    BC_READ  = 2'h2,
    BC_WRITE = 2'h3
  } cpbs_bus_type;

endpackage

// [rtl/cpbs_if.sv]
`timescale 1ns/1ns
interface cpbs_pipe_if #(parameter int unsigned W = 16);
  logic         fill;
  logic [W-1:0] fill_word;
  logic         fill_err;
  logic         flush;
  logic         use_ext;
  logic         start_instr;
  logic [W-1:0] dec_word;
  logic [W-1:0] exe_word;
  logic         buf_valid;
  logic         dec_valid;
  logic         exe_valid;
  logic         dec_err;
  logic         exe_err;
  logic [1:0]   occupancy;
  logic         cof_seen;
  modport ctrl  (output fill, fill_word, fill_err, flush, use_ext, start_instr,
                 input dec_word, exe_word, buf_valid, dec_valid, exe_valid, dec_err,
                 exe_err, occupancy, cof_seen);
  modport stage (input fill, fill_word, fill_err, flush, use_ext, start_instr,
                 output dec_word, exe_word, buf_valid, dec_valid, exe_valid, dec_err,
                 exe_err, occupancy, cof_seen);
endinterface // cpbs_pipe_if

interface cpbs_wbuf_if #(parameter int unsigned AW = 24);
  logic          load;
  logic          done;
  logic [AW-1:0] addr;
  logic [31:0]   data;
  logic [1:0]    size;
  logic          valid;
  logic [AW-1:0] q_addr;
  logic [31:0]   q_data;
  logic [1:0]    q_size;
  modport ctrl (output load, done, addr, data, size, input valid, q_addr, q_data, q_size);
  modport buff (input load, done, addr, data, size, output valid, q_addr, q_data, q_size);
endinterface // cpbs_wbuf_if

// [rtl/cpbs_pipe.sv]
`timescale 1ns/1ns
module cpbs_pipe #(
  parameter int unsigned W         = 16,
  parameter logic [15:0] COF_MASK  = cpbs_pkg::COF_MASK_DEF,
  parameter logic [15:0] COF_MATCH = cpbs_pkg::COF_MATCH_DEF
) (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  cpbs_pipe_if.stage      pif
);

  localparam int unsigned N = cpbs_pkg::PIPE_STAGES;

  logic [W-1:0] word_r [N];
  logic [N-1:0] vld_r;
  logic [N-1:0] err_r;
  logic [W-1:0] word_nxt [N];
  logic [N-1:0] vld_nxt;
  logic [N-1:0] err_nxt;
  logic         b_to_c;
  logic         b_free;
  logic         a_to_b;

  always_comb begin
    b_to_c = vld_r[cpbs_pkg::STG_DEC] && (pif.start_instr || !vld_r[cpbs_pkg::STG_EXE]);
    b_free = !vld_r[cpbs_pkg::STG_DEC] || pif.use_ext || b_to_c;
    a_to_b = vld_r[cpbs_pkg::STG_BUF] && b_free;
    // Execute stage takes the decode word on a full advance or when empty
    vld_nxt[cpbs_pkg::STG_EXE]  = b_to_c ? 1'b1 :
                                  (pif.start_instr ? 1'b0 : vld_r[cpbs_pkg::STG_EXE]);
    word_nxt[cpbs_pkg::STG_EXE] = b_to_c ? word_r[cpbs_pkg::STG_DEC] : word_r[cpbs_pkg::STG_EXE];
    err_nxt[cpbs_pkg::STG_EXE]  = b_to_c ? err_r[cpbs_pkg::STG_DEC] : err_r[cpbs_pkg::STG_EXE];
    vld_nxt[cpbs_pkg::STG_DEC]  = a_to_b ? 1'b1 : (b_free ? 1'b0 : vld_r[cpbs_pkg::STG_DEC]);
    word_nxt[cpbs_pkg::STG_DEC] = a_to_b ? word_r[cpbs_pkg::STG_BUF] : word_r[cpbs_pkg::STG_DEC];
    err_nxt[cpbs_pkg::STG_DEC]  = a_to_b ? err_r[cpbs_pkg::STG_BUF] : err_r[cpbs_pkg::STG_DEC];
    // Fill only lands when the buffer is free; the fetch limiter guarantees it
    vld_nxt[cpbs_pkg::STG_BUF]  = pif.fill ? 1'b1 : (a_to_b ? 1'b0 : vld_r[cpbs_pkg::STG_BUF]);
    word_nxt[cpbs_pkg::STG_BUF] = pif.fill ? pif.fill_word : word_r[cpbs_pkg::STG_BUF];
    err_nxt[cpbs_pkg::STG_BUF]  = pif.fill ? pif.fill_err : err_r[cpbs_pkg::STG_BUF];
  end

  for (genvar i = 0; i < N; i++) begin : g_stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        word_r[i] <= '0;
        vld_r[i]  <= 1'b0;
        err_r[i]  <= 1'b0;
      end else if (pif.flush) begin
        vld_r[i]  <= 1'b0;
        err_r[i]  <= 1'b0;
      end else begin
        word_r[i] <= word_nxt[i];
        vld_r[i]  <= vld_nxt[i];
        err_r[i]  <= err_nxt[i] && vld_nxt[i];
      end
    end
  end

  assign pif.dec_word  = word_r[cpbs_pkg::STG_DEC];
  assign pif.exe_word  = word_r[cpbs_pkg::STG_EXE];
  assign pif.buf_valid = vld_r[cpbs_pkg::STG_BUF];
  assign pif.dec_valid = vld_r[cpbs_pkg::STG_DEC];
  assign pif.exe_valid = vld_r[cpbs_pkg::STG_EXE];
  assign pif.dec_err   = err_r[cpbs_pkg::STG_DEC];
  assign pif.exe_err   = err_r[cpbs_pkg::STG_EXE];
  assign pif.occupancy = 2'(vld_r[0]) + 2'(vld_r[1]) + 2'(vld_r[2]);
  // Opcode pattern in decode marks an imminent change of flow
  assign pif.cof_seen  = vld_r[cpbs_pkg::STG_DEC] &&
                         ((word_r[cpbs_pkg::STG_DEC] & COF_MASK) == COF_MATCH);

endmodule // cpbs_pipe

// [rtl/cpbs_wbuf.sv]
`timescale 1ns/1ns
module cpbs_wbuf (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  cpbs_wbuf_if.buff wif
);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wif.valid <= 1'b0;
    end else if (wif.load) begin
      wif.valid <= 1'b1;
    end else if (wif.done) begin
      wif.valid <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wif.q_addr <= '0;
      wif.q_data <= '0;
      wif.q_size <= 2'h0;
    end else if (wif.load && !wif.valid) begin
      wif.q_addr <= wif.addr;
      wif.q_data <= wif.data;
      wif.q_size <= wif.size;
    end
  end

endmodule // cpbs_wbuf

// [rtl/cpbs_top.sv]
`timescale 1ns/1ns
// Summary of operation
// - Pipeline holds buffer, decode and execute stages of instruction words.
// - Fetched word waits in the buffer stage until decode stage frees.
// - Every stage keeps a bit flagging a word from an errored bus cycle.
// - Prefetcher fills pipeline after change of flow, then keeps refilling it.
// - Prefetching starts at the address given with the sequencer's flow request.
// - A stage freed by instruction start or extension use triggers refetch only once occupancy falls below the room limit.
// - Prefetch waits until no sequencer operand access is pending.
// - Prefetch only with pipeline room and no change-of-flow instruction next.
// - Pipeline flags imminent change of flow; controller withholds wasted prefetches.
// - Change of flow flushes pipeline, then refills from the new stream.
// - Bus work runs concurrently with sequencer internal work.
// - Operand request during a busy bus is queued and run afterwards.
// - One-entry write buffer lets the sequencer continue past a write.
// - Sequencer stalls rather than overwrite an occupied write buffer.
// - Queued operand accesses win over prefetches; a request taken as a prefetch starts waits behind it.
// - Byte and word operands take one bus cycle; interface may split words.
// - Long operands take two bus cycles, upper word first.
// - A bus cycle takes two clocks at least; slower partners stretch it.
// - Replacement prefetch may start early, from the first indexed clock.
// - Replacement prefetch may start two clocks before the end if bus idle.
// - Change of flow ends in a two-clock window allowing an extra word.
// - Fixed arbitration gives the same operand order for the same code.
// - Advance sets receiving stage valid and clears the supplying stage.
module cpbs_top #(
  parameter int unsigned AW        = 24,
  parameter logic [15:0] COF_MASK  = cpbs_pkg::COF_MASK_DEF,
  parameter logic [15:0] COF_MATCH = cpbs_pkg::COF_MATCH_DEF
) (
  input  wire logic          clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          seq_flow_req_in,
  input  wire logic [AW-1:0] seq_flow_addr_in,
  input  wire logic          seq_ext_use_in,
  input  wire logic          seq_instr_start_in,
  input  wire logic          seq_end_near_in,
  input  wire logic          seq_op_req_in,
  input  wire logic          seq_op_we_in,
  input  wire logic [1:0]    seq_op_size_in,
  input  wire logic [AW-1:0] seq_op_addr_in,
  input  wire logic [31:0]   seq_op_wdata_in,
  output logic               seq_op_ack_out,
  output logic               seq_stall_out,
  output logic [31:0]        seq_rdata_out,
  output logic               seq_rdata_valid_out,
  output logic               seq_rdata_err_out,
  output logic [15:0]        ir_dec_word_out,
  output logic               ir_dec_valid_out,
  output logic               ir_dec_err_out,
  output logic [15:0]        ir_exe_word_out,
  output logic               ir_exe_valid_out,
  output logic               ir_exe_err_out,
  output logic               ir_buf_valid_out,
  output logic               bus_req_out,
  output logic [AW-1:0]      bus_addr_out,
  output logic               bus_we_out,
  output logic [1:0]         bus_size_out,
  output logic [15:0]        bus_wdata_out,
  output logic               bus_fetch_out,
  input  wire logic          bus_ack_in,
  input  wire logic          bus_err_in,
  input  wire logic [15:0]   bus_rdata_in
);

  if (AW < 2 || AW > 32) begin : g_chk_aw
    $error("cpbs_top: AW must lie between 2 and 32");
  end

  cpbs_pipe_if #(.W(cpbs_pkg::WORD_W)) pif ();
  cpbs_wbuf_if #(.AW(AW))              wif ();

  cpbs_pipe #(
    .W         (cpbs_pkg::WORD_W),
    .COF_MASK  (COF_MASK),
    .COF_MATCH (COF_MATCH)
  ) u_pipe (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .pif      (pif)
  );

  cpbs_wbuf u_wbuf (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .wif      (wif)
  );

  cpbs_pkg::cpbs_bus_type bus_state_r;
  cpbs_pkg::cpbs_pf_type  pf_state_r;
  logic                   bus_half_r;
  logic                   bus_long_r;
  logic [AW-1:0]          pc_r;
  logic                   drop_r;
  logic [1:0]             idle_cnt_r;
  logic                   rd_valid_r;
  logic [AW-1:0]          rd_addr_r;
  logic [1:0]             rd_size_r;
  logic [15:0]            rd_hi_r;
  logic                   rd_err_r;
  logic                   bus_done;
  logic                   bus_last;
  logic                   can_start;
  logic                   take_wr;
  logic                   take_rd;
  logic                   start_wr;
  logic                   start_rd;
  logic                   start_pf;
  logic                   pf_ok;
  logic [2:0]             room_lim;
  logic [2:0]             occ_total;
  logic                   fetch_live;

  // Each cycle completes on ack; a long needs a second ack
  assign bus_done   = (bus_state_r != cpbs_pkg::BC_IDLE) && bus_ack_in;
  assign bus_last   = bus_done && (!bus_long_r || bus_half_r);
  assign can_start  = (bus_state_r == cpbs_pkg::BC_IDLE) || bus_last;
  assign fetch_live = (bus_state_r == cpbs_pkg::BC_FETCH) && !drop_r;

  // Ack register blocks a second take while the sequencer drops its request
  assign take_wr = seq_op_req_in && seq_op_we_in && !seq_op_ack_out && !wif.valid;
  assign take_rd = seq_op_req_in && !seq_op_we_in && !seq_op_ack_out && !rd_valid_r;

  // Extra word allowed near an instruction end and in the refill window
  assign room_lim  = (pf_state_r == cpbs_pkg::PF_EXTRA || seq_end_near_in) ?
                     cpbs_pkg::PIPE_MAX_WORDS : cpbs_pkg::PIPE_MIN_WORDS;
  assign occ_total = {1'b0, pif.occupancy} + {2'b00, fetch_live};

  assign pf_ok = (pf_state_r != cpbs_pkg::PF_IDLE) && !seq_flow_req_in &&
                 !wif.valid && !rd_valid_r &&
                 !pif.cof_seen &&
                 (occ_total < room_lim);

  // Fixed order: pending write, then pending read, then prefetch
  always_comb begin
    start_wr = 1'b0;
    start_rd = 1'b0;
    start_pf = 1'b0;
    if (can_start) begin
      if (wif.valid && !(bus_last && bus_state_r == cpbs_pkg::BC_WRITE)) begin
        start_wr = 1'b1;
      end else if (rd_valid_r && !(bus_last && bus_state_r == cpbs_pkg::BC_READ)) begin
        start_rd = 1'b1;
      end else if (pf_ok && !(bus_done && bus_state_r == cpbs_pkg::BC_FETCH && drop_r)) begin
        start_pf = 1'b1;
      end
    end
  end

  // Write buffer handshake
  assign wif.load = take_wr;
  assign wif.addr = seq_op_addr_in;
  assign wif.data = seq_op_wdata_in;
  assign wif.size = seq_op_size_in;
  assign wif.done = bus_last && (bus_state_r == cpbs_pkg::BC_WRITE);

  // Pipeline control; a flush in the same cycle as fetch data discards it
  assign pif.fill        = bus_done && fetch_live && !seq_flow_req_in;
  assign pif.fill_word   = bus_rdata_in;
  assign pif.fill_err    = bus_err_in;
  assign pif.flush       = seq_flow_req_in;
  assign pif.use_ext     = seq_ext_use_in;
  assign pif.start_instr = seq_instr_start_in;

  // Bus cycle sequencing; runs alongside sequencer work
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_state_r   <= cpbs_pkg::BC_IDLE;
      bus_half_r    <= 1'b0;
      bus_long_r    <= 1'b0;
      bus_req_out   <= 1'b0;
      bus_addr_out  <= '0;
      bus_we_out    <= 1'b0;
      bus_size_out  <= cpbs_pkg::SZ_WORD;
      bus_wdata_out <= 16'h0000;
      bus_fetch_out <= 1'b0;
    end else if (start_wr) begin
      bus_state_r   <= cpbs_pkg::BC_WRITE;
      bus_half_r    <= 1'b0;
      bus_long_r    <= (wif.q_size == cpbs_pkg::SZ_LONG);
      bus_req_out   <= 1'b1;
      bus_addr_out  <= wif.q_addr;
      bus_we_out    <= 1'b1;
      bus_fetch_out <= 1'b0;
      case (wif.q_size)
        cpbs_pkg::SZ_BYTE: begin
          bus_size_out  <= cpbs_pkg::SZ_BYTE;
          bus_wdata_out <= {wif.q_data[7:0], wif.q_data[7:0]};
        end
        cpbs_pkg::SZ_LONG: begin
          bus_size_out  <= cpbs_pkg::SZ_WORD;
          bus_wdata_out <= wif.q_data[cpbs_pkg::WORD_HI:cpbs_pkg::WORD_LO];
        end
        default: begin
          bus_size_out  <= cpbs_pkg::SZ_WORD;
          bus_wdata_out <= wif.q_data[15:0];
        end
      endcase
    end else if (start_rd) begin
      bus_state_r   <= cpbs_pkg::BC_READ;
      bus_half_r    <= 1'b0;
      bus_long_r    <= (rd_size_r == cpbs_pkg::SZ_LONG);
      bus_req_out   <= 1'b1;
      bus_addr_out  <= rd_addr_r;
      bus_we_out    <= 1'b0;
      bus_size_out  <= (rd_size_r == cpbs_pkg::SZ_BYTE) ? cpbs_pkg::SZ_BYTE : cpbs_pkg::SZ_WORD;
      bus_fetch_out <= 1'b0;
    end else if (start_pf) begin
      bus_state_r   <= cpbs_pkg::BC_FETCH;
      bus_half_r    <= 1'b0;
      bus_long_r    <= 1'b0;
      bus_req_out   <= 1'b1;
      bus_addr_out  <= pc_r;
      bus_we_out    <= 1'b0;
      bus_size_out  <= cpbs_pkg::SZ_WORD;
      bus_fetch_out <= 1'b1;
    end else if (bus_done && !bus_last) begin
      // Lower word of a long follows the upper one
      bus_half_r    <= 1'b1;
      bus_addr_out  <= bus_addr_out + AW'(2);
      bus_wdata_out <= wif.q_data[15:0];
    end else if (bus_last) begin
      bus_state_r   <= cpbs_pkg::BC_IDLE;
      bus_req_out   <= 1'b0;
      bus_we_out    <= 1'b0;
      bus_fetch_out <= 1'b0;
    end
  end

  // Queued read slot
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_valid_r <= 1'b0;
      rd_addr_r  <= '0;
      rd_size_r  <= cpbs_pkg::SZ_WORD;
    end else if (take_rd) begin
      rd_valid_r <= 1'b1;
      rd_addr_r  <= seq_op_addr_in;
      rd_size_r  <= seq_op_size_in;
    end else if (bus_last && bus_state_r == cpbs_pkg::BC_READ) begin
      rd_valid_r <= 1'b0;
    end
  end

  // Read return; upper word of a long is held until the lower arrives
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_hi_r             <= 16'h0000;
      rd_err_r            <= 1'b0;
      seq_rdata_out       <= 32'h0000_0000;
      seq_rdata_valid_out <= 1'b0;
      seq_rdata_err_out   <= 1'b0;
    end else begin
      seq_rdata_valid_out <= 1'b0;
      if (bus_done && bus_state_r == cpbs_pkg::BC_READ) begin
        if (!bus_last) begin
          rd_hi_r  <= bus_rdata_in;
          rd_err_r <= bus_err_in;
        end else begin
          seq_rdata_valid_out <= 1'b1;
          seq_rdata_err_out   <= bus_err_in || (bus_long_r && rd_err_r);
          rd_err_r            <= 1'b0;
          case (rd_size_r)
            cpbs_pkg::SZ_BYTE: seq_rdata_out <= {24'h000000, bus_rdata_in[7:0]};
            cpbs_pkg::SZ_LONG: seq_rdata_out <= {rd_hi_r, bus_rdata_in};
            default:           seq_rdata_out <= {16'h0000, bus_rdata_in};
          endcase
        end
      end
    end
  end

  // Sequencer handshake
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seq_op_ack_out <= 1'b0;
      seq_stall_out  <= 1'b0;
    end else begin
      seq_op_ack_out <= take_wr || take_rd;
      seq_stall_out  <= seq_op_req_in && !seq_op_ack_out && !take_wr && !take_rd;
    end
  end

  // Prefetch address and stale-fetch discard
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_r   <= '0;
      drop_r <= 1'b0;
    end else begin
      if (seq_flow_req_in) begin
        pc_r <= seq_flow_addr_in;
      end else if (start_pf) begin
        pc_r <= pc_r + AW'(2);
      end
      // A fetch still on the bus at a flush belongs to the old stream
      if (seq_flow_req_in && bus_state_r == cpbs_pkg::BC_FETCH && !bus_done) begin
        drop_r <= 1'b1;
      end else if (bus_done && bus_state_r == cpbs_pkg::BC_FETCH) begin
        drop_r <= 1'b0;
      end
    end
  end

  // Prefetch phase: initial fill, refill window, then steady refill
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pf_state_r <= cpbs_pkg::PF_IDLE;
      idle_cnt_r <= cpbs_pkg::IDLE_CNT_RST;
    end else if (seq_flow_req_in) begin
      pf_state_r <= cpbs_pkg::PF_FILL;
      idle_cnt_r <= cpbs_pkg::IDLE_CNT_RST;
    end else begin
      case (pf_state_r)
        cpbs_pkg::PF_FILL: begin
          if ({1'b0, pif.occupancy} >= cpbs_pkg::PIPE_MIN_WORDS) begin
            pf_state_r <= cpbs_pkg::PF_EXTRA;
          end
        end
        cpbs_pkg::PF_EXTRA: begin
          if (idle_cnt_r == 2'(cpbs_pkg::COF_IDLE_CYC - 1)) begin
            pf_state_r <= cpbs_pkg::PF_RUN;
          end else begin
            idle_cnt_r <= idle_cnt_r + 2'h1;
          end
        end
        cpbs_pkg::PF_RUN:  pf_state_r <= cpbs_pkg::PF_RUN;
        default:           pf_state_r <= cpbs_pkg::PF_IDLE;
      endcase
    end
  end

  // Stage views come straight from pipeline flops
  assign ir_dec_word_out  = pif.dec_word;
  assign ir_dec_valid_out = pif.dec_valid;
  assign ir_dec_err_out   = pif.dec_err;
  assign ir_exe_word_out  = pif.exe_word;
  assign ir_exe_valid_out = pif.exe_valid;
  assign ir_exe_err_out   = pif.exe_err;
  assign ir_buf_valid_out = pif.buf_valid;

endmodule // cpbs_top

// [verification/cpbs_monitor.sv]
`timescale 1ns/1ns
module cpbs_monitor #(
  parameter int unsigned AW        = 24,
  parameter logic [15:0] COF_MASK  = cpbs_pkg::COF_MASK_DEF,
  parameter logic [15:0] COF_MATCH = cpbs_pkg::COF_MATCH_DEF
) (
  input wire logic          clk_in,
  input wire logic          rst_b_in,
  input wire logic          seq_flow_req_in,
  input wire logic [AW-1:0] seq_flow_addr_in,
  input wire logic          seq_ext_use_in,
  input wire logic          seq_instr_start_in,
  input wire logic          seq_op_req_in,
  input wire logic          seq_op_ack_out,
  input wire logic [15:0]   ir_dec_word_out,
  input wire logic          ir_dec_valid_out,
  input wire logic          ir_dec_err_out,
  input wire logic [15:0]   ir_exe_word_out,
  input wire logic          ir_exe_valid_out,
  input wire logic          ir_exe_err_out,
  input wire logic          ir_buf_valid_out,
  input wire logic          bus_req_out,
  input wire logic [AW-1:0] bus_addr_out,
  input wire logic          bus_we_out,
  input wire logic          bus_fetch_out,
  input wire logic          bus_ack_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic cof_dec;
  assign cof_dec = ir_dec_valid_out && ((ir_dec_word_out & COF_MASK) == COF_MATCH);

  ack_pulse_a: assert property (seq_op_ack_out |=> !seq_op_ack_out)
    else $error("operand ack too long");
  bus_hold_a: assert property (bus_req_out && !bus_ack_in |=> bus_req_out &&
    $stable(bus_addr_out) && $stable(bus_we_out) && $stable(bus_fetch_out)) else $error("bus moved");
  op_first_a: assert property ($past(seq_op_ack_out) && $rose(bus_req_out) |-> !bus_fetch_out)
    else $error("prefetch beat operand");
  flush_a: assert property (seq_flow_req_in |=> !ir_buf_valid_out && !ir_dec_valid_out &&
    !ir_exe_valid_out && !ir_dec_err_out && !ir_exe_err_out) else $error("no flush");
  flow_fetch_a: assert property (seq_flow_req_in && !bus_req_out && !seq_op_req_in &&
    !seq_op_ack_out |=> ##1 bus_req_out && bus_fetch_out &&
    bus_addr_out == $past(seq_flow_addr_in, 2))
    else $error("no fetch at new address");
  buf_move_a: assert property (ir_buf_valid_out && !ir_dec_valid_out && !seq_flow_req_in
    |=> ir_dec_valid_out) else $error("buffer word stuck");
  exe_move_a: assert property (seq_instr_start_in && ir_dec_valid_out && !seq_flow_req_in
    |=> ir_exe_valid_out && ir_exe_word_out == $past(ir_dec_word_out) &&
    ir_exe_err_out == $past(ir_dec_err_out)) else $error("bad advance");
  cof_hold_a: assert property (cof_dec && !bus_req_out && !seq_instr_start_in &&
    !seq_ext_use_in && !seq_flow_req_in |=> !(bus_req_out && bus_fetch_out))
    else $error("prefetch despite flow change");
endmodule // cpbs_monitor

bind cpbs_top cpbs_monitor #(.AW(AW), .COF_MASK(COF_MASK), .COF_MATCH(COF_MATCH))
  cpbs_monitor_inst (.*);

// [verification/cpbs_mem_model.sv]
`timescale 1ns/1ns
module cpbs_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        req_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [1:0]  wait_in,
  input  wire logic        bad_in,
  output logic             ack_out,
  output logic             err_out,
  output logic [15:0]      rdata_out
);
  logic [1:0] cnt_r;
  // Earliest answer is the clock after req is seen, a two-clock cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= 2'h0;
      ack_out <= 1'b0;
      err_out <= 1'b0;
      rdata_out <= 16'h0;
    end else begin
      ack_out <= 1'b0;
      err_out <= 1'b0;
      // Data lines never keep a stale value between answers
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r + 2'h1 >= wait_in) begin
          cnt_r <= 2'h0;
          ack_out <= 1'b1;
          err_out <= bad_in;
          rdata_out <= {bad_in ? 4'h6 : 4'h1, addr_in[11:0]};
        end
      end
    end
  end
endmodule // cpbs_mem_model

// [verification/tb.sv]
`timescale 1ns/1ns
module tb;
  logic        clk_in = 1'b0, rst_b_in, seq_flow_req_in, seq_ext_use_in, seq_instr_start_in;
  logic        seq_end_near_in, seq_op_req_in, seq_op_we_in, seq_op_ack_out, seq_stall_out;
  logic        seq_rdata_valid_out, seq_rdata_err_out, ir_dec_valid_out, ir_dec_err_out;
  logic        ir_exe_valid_out, ir_exe_err_out, ir_buf_valid_out, bus_req_out, bus_we_out;
  logic        bus_fetch_out, bus_ack_in, bus_err_in, pbad, saw_stall;
  logic [1:0]  seq_op_size_in, bus_size_out, pwait;
  logic [15:0] ir_dec_word_out, ir_exe_word_out, bus_wdata_out, bus_rdata_in;
  logic [23:0] seq_flow_addr_in, seq_op_addr_in, bus_addr_out, a;
  logic [31:0] seq_op_wdata_in, seq_rdata_out, d;
  logic [41:0] q[$];
  int          num_errors = 0, checks = 0, n, n0;

  cpbs_top cpbs_top_inst (.*);
  cpbs_mem_model cpbs_mem_model_inst (.clk_in, .rst_b_in, .req_in(bus_req_out),
    .addr_in(bus_addr_out), .wait_in(pwait), .bad_in(pbad), .ack_out(bus_ack_in),
    .err_out(bus_err_in), .rdata_out(bus_rdata_in));

  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (bus_req_out && bus_ack_in) q.push_back({bus_fetch_out, bus_we_out, bus_addr_out, bus_wdata_out});
  end

  function automatic logic [15:0] word_at(logic [23:0] adr);
    word_at = {4'h1, adr[11:0]};
  endfunction
  task automatic chk(string nm, logic [41:0] seen, logic [41:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic flow(logic [23:0] adr);
    @(posedge clk_in) {seq_flow_req_in, seq_flow_addr_in} <= {1'b1, adr};
    @(posedge clk_in) seq_flow_req_in <= 1'b0;
    q.delete();
    repeat (20) @(posedge clk_in);
  endtask
  // Request held until the ack edge, dropped right after it
  task automatic op(logic we, logic [1:0] sz, logic [23:0] adr, logic [31:0] dat);
    @(posedge clk_in) {seq_instr_start_in, seq_ext_use_in} <= 2'h0;
    {seq_op_req_in, seq_op_we_in, seq_op_size_in, seq_op_addr_in, seq_op_wdata_in} <= {1'b1, we, sz, adr, dat};
    pwait <= 2'($urandom_range(1, 3));
    saw_stall = 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      saw_stall |= seq_stall_out;
      n++;
    end while (seq_op_ack_out !== 1'b1 && n < 60);
    seq_op_req_in <= 1'b0;
    chk("op_ack", seq_op_ack_out, 1'b1);
  endtask
  task automatic complete_run();
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    complete_run();
  end
  initial begin
    {rst_b_in, seq_flow_req_in, seq_ext_use_in, seq_instr_start_in, seq_end_near_in} = '0;
    {seq_op_req_in, seq_op_we_in, seq_op_size_in, seq_op_addr_in, seq_op_wdata_in} = '0;
    {seq_flow_addr_in, pbad, pwait} = {24'h0, 1'b0, 2'h1};
    n = $urandom(32'hf4d8e231);
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    a = {23'($urandom), 1'b0};
    flow(a);
    chk("fetch0", q[0][39:16], a);
    chk("fetch1", q[1][39:16], a + 24'h2);
    chk("fetch_cnt", 42'(q.size() inside {[2:3]}), 1'b1);
    chk("exe_word", ir_exe_word_out, word_at(a));
    chk("dec_word", ir_dec_word_out, word_at(a + 24'h2));
    n0 = q.size();
    @(posedge clk_in) seq_instr_start_in <= 1'b1;
    @(posedge clk_in) {seq_instr_start_in, seq_ext_use_in} <= 2'h1;
    @(posedge clk_in) seq_ext_use_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    chk("exe_adv", ir_exe_word_out, word_at(a + 24'h2));
    chk("refetch", 42'(q.size() > n0), 1'b1);
    pbad <= 1'b1;
    flow(a + 24'h40);
    chk("exe_err", ir_exe_err_out, 1'b1);
    chk("cof_fetch", 42'(q.size() <= 2), 1'b1);
    pbad <= 1'b0;
    q.delete();
    d = $urandom;
    op(1'b1, 2'h2, a, d);
    op(1'b1, 2'h1, a + 24'h8, ~d);
    chk("stall", saw_stall, 1'b1);
    repeat (20) @(posedge clk_in);
    chk("long_hi", q[0], {2'b01, a, d[31:16]});
    chk("long_lo", q[1], {2'b01, a + 24'h2, d[15:0]});
    chk("queued", q[2], {2'b01, a + 24'h8, ~d[15:0]});
    flow(a);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_in) {seq_instr_start_in, seq_ext_use_in} <= 2'($urandom_range(0, 3));
      a = {23'($urandom), 1'b0};
      n0 = $urandom_range(0, 2);
      op(1'b0, 2'(n0), a, 32'h0);
      do @(posedge clk_in); while (seq_rdata_valid_out !== 1'b1 && ++n < 120);
      d = (n0 == 2) ? {word_at(a), word_at(a + 24'h2)} :
          (n0 == 0) ? {16'h0, word_at(a) & 16'h00ff} : {16'h0, word_at(a)};
      chk("rdata", seq_rdata_out, d);
      chk("rerr", seq_rdata_err_out, 1'b0);
    end
    complete_run();
  end
endmodule // tb
